// *** hdl/vss_map.vh ***
/*
 * Constants for the display sync/mode sequencer host: register map,
 * field layout, reset values and pin timing.
 * Included by the host module; definitions only.
 */
`ifndef VSS_MAP_VH
`define VSS_MAP_VH

// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define VSS_OFS_CTRL 5'h00
`define VSS_OFS_CFG 5'h04
`define VSS_OFS_ADDR 5'h08
`define VSS_OFS_DATA 5'h0c
`define VSS_OFS_CMD 5'h10
`define VSS_OFS_STAT 5'h14

// ****************************************************************
// Fields
// ****************************************************************
`define VSS_CTRL_POR_BIT 0
`define VSS_CFG_STD_LSB 0
`define VSS_CFG_STD_MSB 1
`define VSS_CFG_XTAL_BIT 2
`define VSS_CFG_FSC_BIT 3
`define VSS_STD_NTSC 2'h0
`define VSS_STD_PAL 2'h1
`define VSS_STD_SELECT_A 2'h2
`define VSS_WAIT_NONE 2'h0
`define VSS_WAIT_20 2'h1
`define VSS_WAIT_30 2'h2
`define VSS_WAIT_200 2'h3
`define VSS_CFG_RESET 4'h0

// Superimpose control location in the device map
`define VSS_COLOR_SUPERIMPOSE_ENABLE_ADDR 24'h0002b0
`define VSS_COLOR_SUPERIMPOSE_ENABLE_MASK 24'h000001

// Frame byte positions, counted from 0: last address byte, last data byte
`define VSS_BYTE_ADDR_END 3'h2
`define VSS_BYTE_DATA_END 3'h5

// ****************************************************************
// Timing
// ****************************************************************
`define VSS_CLK_NS 25
`define VSS_MS_NS 1000000
`define VSS_T_SCK_NS 200
`define VSS_T_CSSU_NS 200
`define VSS_T_ADSU_NS 200
`define VSS_T_ADH_NS 200
`define VSS_T_CSH_NS 2000
`define VSS_T_WORDH_NS 2000
`define VSS_T_ACLOW_MS 1
`define VSS_T_POR_MS 200
`define VSS_T_OSC_MS 20
`define VSS_T_INTL_MS 30

`endif

// *** hdl/vss_host.v ***
/*
 * Host-side sequencer for an on-screen character display controller.
 * Drives auto-clear, chip select, strobe and the 8-bit data pins, runs
 * the start-up and settling waits, and takes orders over APB.
 * Assumes pclk at 40 MHz and a line sync input from the video path.
 */
// Implementation choices: the placing of the registers and the APB slave port.
//
// Contract
// - Crystal subcarrier forces superimpose control to zero
// - Superimpose settings per standard set by software
// - Burst phase low for NTSC, toggles otherwise
// - Subcarrier starts 20 ms before oscillator stable
// - Display off, then 20 ms without data
// - Sync, standard high, interlaced, then 30 ms
// - Then noninterlace and 628-line select high
// - Load registers and RAMs before display enable
// - Pass through interlaced mode before field fixing
// - Auto-clear low, release, 200 ms before writing
// - First write oscillator level bits, 20 ms
// - Tuning bits, 20 ms, rest, then display on
// - Three address bytes, then 24-bit data words
`timescale 1ns/1ps
`include "vss_map.vh"

module vss_host #(
    parameter CYC_PER_MS = 40000
) (
    // APB slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Device pins
    output reg auto_clear_n,
    output reg cs_n,
    output reg sck,
    output reg [7:0] ad,
    output reg burst_phase_input,
    output reg subcarrier_enable,
    // Video line sync from outside
    input wire line_sync
);

    // ****************************************************************
    // Timing counts
    // ****************************************************************
    localparam CYC_SCK = (`VSS_T_SCK_NS + `VSS_CLK_NS - 1) / `VSS_CLK_NS;
    localparam CYC_CSSU = (`VSS_T_CSSU_NS + `VSS_CLK_NS - 1) / `VSS_CLK_NS;
    localparam CYC_ADSU = (`VSS_T_ADSU_NS + `VSS_CLK_NS - 1) / `VSS_CLK_NS;
    localparam CYC_ADH = (`VSS_T_ADH_NS + `VSS_CLK_NS - 1) / `VSS_CLK_NS;
    localparam CYC_CSH = (`VSS_T_CSH_NS + `VSS_CLK_NS - 1) / `VSS_CLK_NS;
    localparam CYC_WORDH = (`VSS_T_WORDH_NS + `VSS_CLK_NS - 1) / `VSS_CLK_NS;

    localparam TW = 20;
    localparam [TW-1:0] MS_RELOAD = CYC_PER_MS - 1;

    // Loads at counter width; 20 bits cap CYC_PER_MS near one million
    localparam [TW-1:0] LD_SCK = CYC_SCK - 1;
    localparam [TW-1:0] LD_CSSU = CYC_CSSU - 1;
    localparam [TW-1:0] LD_ADSU = CYC_ADSU - 1;
    localparam [TW-1:0] LD_ADH = CYC_ADH - 1;
    localparam [TW-1:0] LD_CSH = CYC_CSH - 1;
    localparam [TW-1:0] LD_WORDH = CYC_WORDH - 1;

    // Millisecond counts at the width of the ms counter
    localparam [7:0] MS_ACLOW = `VSS_T_ACLOW_MS;
    localparam [7:0] MS_POR = `VSS_T_POR_MS;
    localparam [7:0] MS_OSC = `VSS_T_OSC_MS;
    localparam [7:0] MS_INTL = `VSS_T_INTL_MS;

    // Last address byte and last data byte of a frame
    localparam [2:0] BYTE_ADDR_END = `VSS_BYTE_ADDR_END;
    localparam [2:0] BYTE_DATA_END = `VSS_BYTE_DATA_END;

    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_ACLOW = 4'h1;
    localparam [3:0] ST_WAIT = 4'h2;
    localparam [3:0] ST_CSSU = 4'h3;
    localparam [3:0] ST_ADSU = 4'h4;
    localparam [3:0] ST_STRB = 4'h5;
    localparam [3:0] ST_ADH = 4'h6;
    localparam [3:0] ST_WORDH = 4'h7;
    localparam [3:0] ST_CSH = 4'h8;

    // ****************************************************************
    // APB register file
    // ****************************************************************
    reg [3:0] cfg_q;
    reg [23:0] addr_q;
    reg [23:0] data_q;
    reg [3:0] state_q;
    reg [TW-1:0] tmr_q;
    reg [7:0] ms_q;
    reg [47:0] word_q;
    reg [2:0] byte_q;
    reg [1:0] wait_q;
    reg [7:0] wait_ms;
    reg [31:0] rd_d;
    reg err_d;

    wire [4:0] ofs = paddr[4:0];
    wire mapped = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0) &&
        (ofs <= `VSS_OFS_STAT);
    wire wr_acc = psel & penable & pready & pwrite & ~pslverr;
    wire idle = (state_q == ST_IDLE);
    wire launch = wr_acc && (ofs == `VSS_OFS_CMD);
    wire por_go = wr_acc && (ofs == `VSS_OFS_CTRL) && pwdata[`VSS_CTRL_POR_BIT];
    wire [1:0] std = cfg_q[`VSS_CFG_STD_MSB:`VSS_CFG_STD_LSB];

    // Superimpose is impossible with a crystal subcarrier
    wire color_superimpose_enable_hit = cfg_q[`VSS_CFG_XTAL_BIT] && (addr_q == `VSS_COLOR_SUPERIMPOSE_ENABLE_ADDR);
    wire [23:0] data_eff = color_superimpose_enable_hit ? (data_q & ~`VSS_COLOR_SUPERIMPOSE_ENABLE_MASK) : data_q;

    always @* begin
        rd_d = 32'h0;
        err_d = ~mapped;
        case (ofs)
            `VSS_OFS_CFG: rd_d = {28'h0, cfg_q};
            `VSS_OFS_ADDR: rd_d = {8'h0, addr_q};
            `VSS_OFS_DATA: rd_d = {8'h0, data_q};
            `VSS_OFS_STAT: rd_d = {24'h0, ms_q[3:0], state_q};
            default: rd_d = 32'h0;
        endcase
        // Orders and new words are refused while a frame or wait runs
        if (pwrite && !idle && ofs != `VSS_OFS_STAT)
            err_d = 1'b1;
        if (!mapped)
            rd_d = 32'h0;
    end

    // Answer one cycle into the access phase, from flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            cfg_q <= `VSS_CFG_RESET;
            addr_q <= 24'h0;
            data_q <= 24'h0;
        end else begin
            pready <= psel & ~penable;
            if (psel & ~penable) begin
                pslverr <= err_d;
                prdata <= pwrite ? 32'h0 : rd_d;
            end else begin
                // Answer stands for the one access cycle only
                pslverr <= 1'b0;
                prdata <= 32'h0;
            end
            if (wr_acc) begin
                case (ofs)
                    `VSS_OFS_CFG: cfg_q <= pwdata[3:0];
                    `VSS_OFS_ADDR: addr_q <= pwdata[23:0];
                    `VSS_OFS_DATA: data_q <= pwdata[23:0];
                    default: cfg_q <= cfg_q;
                endcase
            end
        end
    end

    // ****************************************************************
    // Line sync and burst phase
    // ****************************************************************
    reg ls_m_q;
    reg ls_s_q;
    reg ls_p_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ls_m_q <= 1'b0;
            ls_s_q <= 1'b0;
            ls_p_q <= 1'b0;
            burst_phase_input <= 1'b0;
            subcarrier_enable <= 1'b0;
        end else begin
            ls_m_q <= line_sync;
            ls_s_q <= ls_m_q;
            ls_p_q <= ls_s_q;
            // Software raises it ahead of the internal sync switch
            subcarrier_enable <= cfg_q[`VSS_CFG_FSC_BIT];
            if (std == `VSS_STD_NTSC)
                burst_phase_input <= 1'b0;
            else if (ls_s_q & ~ls_p_q)
                burst_phase_input <= ~burst_phase_input;
        end
    end

    // ****************************************************************
    // Sequencer and word transmitter
    // ****************************************************************
    always @* begin
        case (wait_q)
            `VSS_WAIT_20: wait_ms = MS_OSC;
            `VSS_WAIT_30: wait_ms = MS_INTL;
            `VSS_WAIT_200: wait_ms = MS_POR;
            default: wait_ms = 8'h0;
        endcase
    end

    wire tmr_done = (tmr_q == {TW{1'b0}});

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_ACLOW;
            auto_clear_n <= 1'b0;
            cs_n <= 1'b1;
            sck <= 1'b1;
            ad <= 8'h0;
            tmr_q <= MS_RELOAD;
            ms_q <= MS_ACLOW;
            word_q <= 48'h0;
            byte_q <= 3'h0;
            wait_q <= `VSS_WAIT_NONE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (por_go) begin
                        auto_clear_n <= 1'b0;
                        tmr_q <= MS_RELOAD;
                        ms_q <= MS_ACLOW;
                        state_q <= ST_ACLOW;
                    end else if (launch) begin
                        word_q <= {addr_q, data_eff};
                        wait_q <= pwdata[1:0];
                        byte_q <= 3'h0;
                        cs_n <= 1'b0;
                        tmr_q <= LD_CSSU;
                        state_q <= ST_CSSU;
                    end
                end
                ST_ACLOW: begin
                    if (!tmr_done) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else if (ms_q != 8'h1) begin
                        ms_q <= ms_q - 1'b1;
                        tmr_q <= MS_RELOAD;
                    end else begin
                        // Release, then hold off all writes
                        auto_clear_n <= 1'b1;
                        ms_q <= MS_POR;
                        tmr_q <= MS_RELOAD;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!tmr_done) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else if (ms_q != 8'h1) begin
                        ms_q <= ms_q - 1'b1;
                        tmr_q <= MS_RELOAD;
                    end else begin
                        ms_q <= 8'h0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_CSSU: begin
                    if (!tmr_done) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else begin
                        ad <= word_q[47:40];
                        tmr_q <= LD_ADSU;
                        state_q <= ST_ADSU;
                    end
                end
                ST_ADSU: begin
                    if (!tmr_done) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else begin
                        sck <= 1'b0;
                        tmr_q <= LD_SCK;
                        state_q <= ST_STRB;
                    end
                end
                ST_STRB: begin
                    if (!tmr_done) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else begin
                        // Byte taken on the rising strobe
                        sck <= 1'b1;
                        tmr_q <= LD_ADH;
                        state_q <= ST_ADH;
                    end
                end
                ST_ADH: begin
                    if (!tmr_done) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else begin
                        word_q <= {word_q[39:0], 8'h0};
                        byte_q <= byte_q + 1'b1;
                        if (byte_q == BYTE_DATA_END) begin
                            tmr_q <= LD_CSH;
                            state_q <= ST_CSH;
                        end else if (byte_q == BYTE_ADDR_END) begin
                            // Word gap between address and data bytes
                            tmr_q <= LD_WORDH;
                            state_q <= ST_WORDH;
                        end else begin
                            ad <= word_q[39:32];
                            tmr_q <= LD_ADSU;
                            state_q <= ST_ADSU;
                        end
                    end
                end
                ST_WORDH: begin
                    if (!tmr_done) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else begin
                        ad <= word_q[47:40];
                        tmr_q <= LD_ADSU;
                        state_q <= ST_ADSU;
                    end
                end
                ST_CSH: begin
                    if (!tmr_done) begin
                        tmr_q <= tmr_q - 1'b1;
                    end else begin
                        cs_n <= 1'b1;
                        // Settling waits after oscillator or mode writes
                        if (wait_q == `VSS_WAIT_NONE) begin
                            state_q <= ST_IDLE;
                        end else begin
                            ms_q <= wait_ms;
                            tmr_q <= MS_RELOAD;
                            state_q <= ST_WAIT;
                        end
                    end
                end
                default: begin
                    cs_n <= 1'b1;
                    sck <= 1'b1;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// *** dv/vss_checker.sv ***
/* Assertion checker for the display sequencer host, watching its ports.
   Assumes it is bound into vss_host with the same CYC_PER_MS. */
`timescale 1ns/1ps
module vss_checker #(
    parameter CYC_PER_MS = 40000
) (
    // Clock and reset
    input logic pclk,
    input logic presetn,
    // Device pins and video line sync
    input logic auto_clear_n,
    input logic cs_n,
    input logic sck,
    input logic [7:0] ad,
    input logic burst_phase_input,
    input logic line_sync
);
    logic [31:0] low_q;
    logic [31:0] high_q;
    logic [3:0] bytes_q;
    logic [3:0] since_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************************************
    // Helper counters
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= 32'h0;
            high_q <= 32'h0;
            bytes_q <= 4'h0;
            since_q <= 4'hf;
        end else begin
            low_q <= auto_clear_n ? 32'h0 : low_q + 32'h1;
            high_q <= !auto_clear_n ? 32'h0 : (high_q == 32'hffffffff ? high_q : high_q + 32'h1);
            bytes_q <= cs_n ? 4'h0 : ($rose(sck) ? bytes_q + 4'h1 : bytes_q);
            since_q <= $rose(line_sync) ? 4'h0 : (since_q == 4'hf ? since_q : since_q + 4'h1);
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    sequence strobe_low;
        !sck [*8] ##1 sck;
    endsequence
    sequence cs_lead;
        sck [*8];
    endsequence
    chk_ac_blocks_cs: assert property (!auto_clear_n |-> cs_n)
        else $error("frame during auto-clear");
    chk_ac_low_time: assert property ($rose(auto_clear_n) |-> low_q >= CYC_PER_MS - 1)
        else $error("auto-clear pulse too short");
    chk_por_quiet: assert property ($fell(cs_n) |-> high_q >= 200 * CYC_PER_MS - 1)
        else $error("frame inside start-up wait");
    chk_strobe_width: assert property ($fell(sck) |-> strobe_low)
        else $error("strobe low width wrong");
    chk_ad_setup: assert property (!sck |-> $stable(ad))
        else $error("byte moved while strobe low");
    chk_ad_hold: assert property ($rose(sck) |-> $stable(ad) [*8])
        else $error("byte hold too short");
    chk_cs_lead: assert property ($fell(cs_n) |-> cs_lead)
        else $error("strobe too soon after select");
    chk_frame_bytes: assert property ($rose(cs_n) |-> bytes_q == 4'h6)
        else $error("frame byte count wrong");
    chk_sck_framed: assert property (!sck |-> !cs_n)
        else $error("strobe outside frame");
    chk_burst_cause: assert property ($rose(burst_phase_input) |-> since_q <= 4'h8)
        else $error("burst phase rose without line sync");
endmodule

// *** dv/vss_dev_model.sv ***
/* Behavioural model of the display controller's write port.
   Assumes bytes are taken on the rising strobe while selected. */
`timescale 1ns/1ps
module vss_dev_model #(
    parameter logic [23:0] LVL_ADDR = 24'h000000,
    parameter logic [23:0] DSP_ADDR = 24'h000001
) (
    // Device pins
    input logic auto_clear_n,
    input logic cs_n,
    input logic sck,
    input logic [7:0] ad,
    // Observed state
    output logic [23:0] last_addr,
    output logic [23:0] last_data,
    output int words,
    output logic osc_run
);
    logic [23:0] sh;
    logic [23:0] cur;
    logic lvl1;
    logic dsp;
    int nb;
    always @(negedge cs_n) nb = 0;
    always @(posedge sck or negedge auto_clear_n) begin
        if (!auto_clear_n) begin
            nb = 0;
            words = 0;
            lvl1 = 1'b0;
            dsp = 1'b0;
            last_addr = 24'h0;
            last_data = 24'h0;
        end else if (!cs_n) begin
            sh = {sh[15:0], ad};
            nb = nb + 1;
            if (nb == 3) begin
                cur = sh;
            end else if (nb > 3 && nb % 3 == 0) begin
                last_addr = cur;
                last_data = sh;
                words = words + 1;
                if (cur == LVL_ADDR) lvl1 = sh[1];
                if (cur == DSP_ADDR) dsp = |sh[1:0];
                cur = cur + 24'h1;
            end
        end
    end
    assign osc_run = !(lvl1 && !dsp && cs_n);
endmodule

// *** dv/testbench.sv ***
/* Self-checking bench for vss_host with a device model on its pins.
   Assumes CYC_PER_MS is shortened to 40 so every wait scales down. */
`timescale 1ns/1ps
module testbench;
    localparam int CYC = 40;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, b0;
    logic auto_clear_n, cs_n, sck, burst_phase_input, subcarrier_enable, line_sync, osc_run;
    logic [31:0] paddr, pwdata, prdata, r, d;
    logic [31:0] seed = 32'h3d23;
    logic [7:0] ad;
    logic [23:0] last_addr, last_data;
    int words, t0;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    vss_host #(.CYC_PER_MS(CYC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .auto_clear_n(auto_clear_n), .cs_n(cs_n),
        .sck(sck), .ad(ad), .burst_phase_input(burst_phase_input),
        .subcarrier_enable(subcarrier_enable), .line_sync(line_sync));
    vss_dev_model model (.auto_clear_n(auto_clear_n), .cs_n(cs_n), .sck(sck), .ad(ad),
        .last_addr(last_addr), .last_data(last_data), .words(words), .osc_run(osc_run));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int ms_of(input logic [1:0] w);
        return w == 2'h1 ? 20 : w == 2'h2 ? 30 : w == 2'h3 ? 200 : 0;
    endfunction
    task automatic finish_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checked++;
        if (g !== x) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Setup then access, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle();
        do apb(1'b0, 32'h14, 32'h0, r, e); while (r[3:0] !== 4'h0);
    endtask
    task automatic frame(input logic [23:0] a, input logic [23:0] dd, input logic [23:0] xd,
                         input logic [1:0] w);
        int t;
        apb(1'b1, 32'h8, {8'h0, a}, r, e);
        apb(1'b1, 32'hc, {8'h0, dd}, r, e);
        apb(1'b1, 32'h10, {30'h0, w}, r, e);
        t = cyc;
        apb(1'b1, 32'h10, {30'h0, w}, r, e);
        chk(e, 1);
        idle();
        chk(cyc - t >= ms_of(w) * CYC, 1);
        chk(last_addr, a);
        chk(last_data, xd);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, line_sync} = 4'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        repeat (16) @(posedge pclk);
        chk(auto_clear_n, 0);
        chk(cs_n, 1);
        presetn <= 1'b1;
        t0 = cyc;
        apb(1'b1, 32'h10, 32'h0, r, e);
        chk(e, 1);
        idle();
        chk(cyc - t0 >= 201 * CYC, 1);
        apb(1'b0, 32'h18, 32'h0, r, e);
        chk({r[30:0], e}, 1);
        for (int i = 0; i < 3; i++) begin
            d = (rnd() % 3) | (rnd() & 32'h8);
            apb(1'b1, 32'h4, d, r, e);
            apb(1'b0, 32'h4, 32'h0, r, e);
            chk(r, d);
            chk(subcarrier_enable, d[3]);
        end
        for (int w = 0; w < 4; w++) begin
            d = rnd();
            r = rnd();
            frame(r[23:0], d[23:0], d[23:0], w[1:0]);
        end
        apb(1'b1, 32'h4, 32'h4, r, e);
        frame(24'h0002b0, 24'hffffff, 24'hfffffe, 2'h0);
        frame(24'h0002b1, 24'hffffff, 24'hffffff, 2'h0);
        apb(1'b1, 32'h4, 32'h0, r, e);
        frame(24'h0002b0, 24'hffffff, 24'hffffff, 2'h0);
        frame(24'h000000, 24'h000002, 24'h000002, 2'h0);
        chk(osc_run, 0);
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, 32'h4, s, r, e);
            b0 = burst_phase_input;
            repeat (4 - s) begin
                line_sync <= 1'b1;
                repeat (6) @(posedge pclk);
                line_sync <= 1'b0;
                repeat (6) @(posedge pclk);
            end
            chk(burst_phase_input, s == 0 ? 1'b0 : b0 ^ s[0]);
        end
        apb(1'b1, 32'h0, 32'h1, r, e);
        chk(e, 0);
        repeat (4) @(posedge pclk);
        chk(auto_clear_n, 0);
        chk(words, 0);
        chk(osc_run, 1);
        idle();
        finish_test();
    end
endmodule
bind vss_host vss_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.pclk(pclk), .presetn(presetn),
    .auto_clear_n(auto_clear_n), .cs_n(cs_n), .sck(sck), .ad(ad),
    .burst_phase_input(burst_phase_input), .line_sync(line_sync));
